// *** core/tmc_timer.sv ***
// Purpose: clock select, prescaler and 8-bit up/down counter with flags
// Assumes: control bits arrive as plain ports on clk_in
// Notes: compare values are written directly, no double buffering
`timescale 1ns/1ps
`include "tmc_consts.svh"
module tmc_timer
  import tmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [2:0] clock_source_select_in,
  input wire logic waveform_mode_bit0_in,
  input wire logic waveform_mode_bit1_in,
  input wire logic waveform_mode_bit2_in,
  input wire logic prescaler_reset_in,
  input wire logic external_count_pin_in,
  input wire logic count_wr_in,
  input wire logic [7:0] count_wdata_in,
  input wire logic compare_a_wr_in,
  input wire logic [7:0] compare_a_wdata_in,
  input wire logic compare_b_wr_in,
  input wire logic [7:0] compare_b_wdata_in,
  input wire logic [2:0] flag_clear_in,
  input wire logic [2:0] flag_ack_in,
  input wire logic overflow_mask_in,
  input wire logic compare_a_mask_in,
  input wire logic compare_b_mask_in,
  output logic [7:0] timer_count_value_out,
  output logic [7:0] compare_value_a_out,
  output logic [7:0] compare_value_b_out,
  output logic overflow_flag_out,
  output logic compare_flag_a_out,
  output logic compare_flag_b_out,
  output logic overflow_irq_out,
  output logic compare_a_irq_out,
  output logic compare_b_irq_out,
  output logic timer_tick_out,
  output logic count_at_max_out,
  output logic count_at_bottom_out,
  output logic count_down_out,
  output logic match_a_out,
  output logic match_b_out
);
  tmc_core_s st_ff;
  tmc_core_s nxt_st;
  logic pin_rise;
  logic pin_fall;
  logic tap8;
  logic tap64;
  logic tap256;
  logic tap1024;
  logic timer_tick;
  logic [2:0] waveform_mode;
  logic is_pc;
  logic is_fast;
  logic is_ctc;
  tmc_byte_t top;
  logic match_a;
  logic match_b;
  logic set_ovf;
  logic set_a;
  logic set_b;
  logic [2:0] flag_drop;

  // pin edges come from the synchroniser
  tmc_pin_sync u_pin_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .external_count_pin_in(external_count_pin_in),
    .pin_rise_out(pin_rise),
    .pin_fall_out(pin_fall)
  );

  // taps of the shared chain
  // a tap fires when all lower chain bits are ones, once per divisor period
  always_comb begin
    tap8 = (st_ff.psc & `TMC_PSC_M8) == `TMC_PSC_M8;
    tap64 = (st_ff.psc & `TMC_PSC_M64) == `TMC_PSC_M64;
    tap256 = (st_ff.psc & `TMC_PSC_M256) == `TMC_PSC_M256;
    tap1024 = (st_ff.psc & `TMC_PSC_M1024) == `TMC_PSC_M1024;
  end

  // tick source multiplexer
  // external edges go straight through, never through the chain
  always_comb begin
    case (clock_source_select_in)
      `TMC_CS_STOP: begin
        timer_tick = 1'b0;
      end
      `TMC_CS_DIRECT: begin
        timer_tick = 1'b1;
      end
      `TMC_CS_DIV8: begin
        timer_tick = tap8;
      end
      `TMC_CS_DIV64: begin
        timer_tick = tap64;
      end
      `TMC_CS_DIV256: begin
        timer_tick = tap256;
      end
      `TMC_CS_DIV1024: begin
        timer_tick = tap1024;
      end
      `TMC_CS_EXT_FALL: begin
        timer_tick = pin_fall;
      end
      `TMC_CS_EXT_RISE: begin
        timer_tick = pin_rise;
      end
      default: begin
        timer_tick = 1'b0;
      end
    endcase
  end

  assign waveform_mode = {waveform_mode_bit2_in, waveform_mode_bit1_in, waveform_mode_bit0_in};

  // mode class and top value
  // reserved modes 4 and 6 fall back to the plain up-count sequence
  always_comb begin
    is_pc = (waveform_mode == `TMC_WM_PC_MAX) || (waveform_mode == `TMC_WM_PC_CMPA);
    is_fast = (waveform_mode == `TMC_WM_FAST_MAX) || (waveform_mode == `TMC_WM_FAST_CMPA);
    is_ctc = waveform_mode == `TMC_WM_CTC;
    if (waveform_mode_bit2_in || is_ctc) begin
      top = st_ff.cmp_a;
    end else begin
      top = `TMC_MAX;
    end
  end

  always_comb begin
    match_a = st_ff.cnt == st_ff.cmp_a;
    match_b = st_ff.cnt == st_ff.cmp_b;
  end

  // next state of the core
  always_comb begin
    nxt_st = st_ff;
    set_ovf = 1'b0;
    nxt_st.psc = st_ff.psc + tmc_psc_t'(1);
    if (prescaler_reset_in) begin
      nxt_st.psc = `TMC_PSC_RST;
    end
    if (timer_tick) begin
      if (is_pc) begin
        // dual slope: turn at top, overflow at bottom
        if (!st_ff.count_down) begin
          if (st_ff.cnt == top) begin
            nxt_st.count_down = 1'b1;
            nxt_st.cnt = st_ff.cnt - tmc_byte_t'(1);
          end else begin
            nxt_st.cnt = st_ff.cnt + tmc_byte_t'(1);
          end
        end else begin
          if (st_ff.cnt == `TMC_BOTTOM) begin
            nxt_st.count_down = 1'b0;
            nxt_st.cnt = st_ff.cnt + tmc_byte_t'(1);
            set_ovf = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt - tmc_byte_t'(1);
          end
        end
      end else if (is_fast || is_ctc) begin
        nxt_st.count_down = 1'b0;
        if (st_ff.cnt == top) begin
          nxt_st.cnt = `TMC_BOTTOM;
        end else begin
          nxt_st.cnt = st_ff.cnt + tmc_byte_t'(1);
        end
        // single-slope overflow point
        // ctc overflows only on the wrap from max, fast pwm at its top
        if (is_fast) begin
          set_ovf = st_ff.cnt == top;
        end else begin
          set_ovf = st_ff.cnt == `TMC_MAX;
        end
      end else begin
        nxt_st.count_down = 1'b0;
        nxt_st.cnt = st_ff.cnt + tmc_byte_t'(1);
        set_ovf = st_ff.cnt == `TMC_MAX;
      end
    end
    if (count_wr_in) begin
      nxt_st.cnt = count_wdata_in;
    end
    // block armed by a count write
    // cleared by the next tick only; a write on a tick re-arms it
    if (count_wr_in) begin
      nxt_st.block = 1'b1;
    end else if (timer_tick) begin
      nxt_st.block = 1'b0;
    end
    if (compare_a_wr_in) begin
      nxt_st.cmp_a = compare_a_wdata_in;
    end
    if (compare_b_wr_in) begin
      nxt_st.cmp_b = compare_b_wdata_in;
    end
    // flag update; a set in the clear cycle survives
    nxt_st.flg_ovf = (st_ff.flg_ovf & ~flag_drop[`TMC_FLG_OVF]) | set_ovf;
    nxt_st.flg_a = (st_ff.flg_a & ~flag_drop[`TMC_FLG_A]) | set_a;
    nxt_st.flg_b = (st_ff.flg_b & ~flag_drop[`TMC_FLG_B]) | set_b;
  end

  // match raises its flag on the tick
  always_comb begin
    set_a = timer_tick && match_a && !st_ff.block;
    set_b = timer_tick && match_b && !st_ff.block;
    flag_drop = flag_clear_in | flag_ack_in;
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign timer_count_value_out = st_ff.cnt;
  assign compare_value_a_out = st_ff.cmp_a;
  assign compare_value_b_out = st_ff.cmp_b;
  assign overflow_flag_out = st_ff.flg_ovf;
  assign compare_flag_a_out = st_ff.flg_a;
  assign compare_flag_b_out = st_ff.flg_b;

  assign overflow_irq_out = st_ff.flg_ovf & overflow_mask_in;
  assign compare_a_irq_out = st_ff.flg_a & compare_a_mask_in;
  assign compare_b_irq_out = st_ff.flg_b & compare_b_mask_in;

  assign count_at_max_out = st_ff.cnt == `TMC_MAX;
  assign count_at_bottom_out = st_ff.cnt == `TMC_BOTTOM;
  assign count_down_out = st_ff.count_down;
  assign match_a_out = match_a;
  assign match_b_out = match_b;
  assign timer_tick_out = timer_tick;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  chk_stop_hold: assert property (
    clock_source_select_in == `TMC_CS_STOP && !count_wr_in |=> $stable(st_ff.cnt))
    else $error("counter moved while stopped");

  chk_write_wins: assert property (
    count_wr_in |=> timer_count_value_out == $past(count_wdata_in))
    else $error("count write lost");

  chk_direct_tick: assert property (
    clock_source_select_in == `TMC_CS_DIRECT |-> timer_tick)
    else $error("direct select missed a tick");

  chk_tap_gap: assert property (
    tap8 |=> !tap8 [*7])
    else $error("divide-by-8 tap too frequent");

  chk_pin_direct: assert property (
    clock_source_select_in == `TMC_CS_EXT_RISE && pin_rise |-> timer_tick)
    else $error("pin edge did not tick");

  chk_normal_wrap: assert property (
    timer_tick && waveform_mode == `TMC_WM_NORMAL && st_ff.cnt == `TMC_MAX
      && !count_wr_in |=> timer_count_value_out == `TMC_BOTTOM && overflow_flag_out)
    else $error("normal wrap or overflow wrong");

  chk_ctc_clear: assert property (
    timer_tick && is_ctc && match_a && !count_wr_in |=> timer_count_value_out == `TMC_BOTTOM)
    else $error("counter not cleared at compare a");

  chk_match_block: assert property (
    count_wr_in ##1 (timer_tick && !compare_flag_a_out) |=> !compare_flag_a_out)
    else $error("match after count write set flag");

  chk_flag_sticky: assert property (
    compare_flag_b_out && !flag_clear_in[`TMC_FLG_B] && !flag_ack_in[`TMC_FLG_B]
      |=> compare_flag_b_out)
    else $error("compare flag b dropped on its own");

  chk_irq_gate: assert property (
    overflow_irq_out |-> overflow_flag_out && overflow_mask_in)
    else $error("overflow irq without flag and mask");

  chk_match_sets: assert property (
    timer_tick && match_a && !st_ff.block |=> compare_flag_a_out)
    else $error("match failed to set compare flag a");

  chk_pc_bottom: assert property (
    timer_tick && is_pc && st_ff.count_down && st_ff.cnt == `TMC_BOTTOM && !count_wr_in
      |=> overflow_flag_out && !count_down_out)
    else $error("dual slope bottom turn wrong");

  chk_fast_top: assert property (
    timer_tick && is_fast && st_ff.cnt == top && !count_wr_in
      |=> timer_count_value_out == `TMC_BOTTOM && overflow_flag_out)
    else $error("fast mode top not handled");

  chk_psc_reset: assert property (
    prescaler_reset_in |=> st_ff.psc == `TMC_PSC_RST)
    else $error("prescaler chain not cleared");

  chk_flag_clear: assert property (
    flag_clear_in[`TMC_FLG_OVF] && !set_ovf |=> !overflow_flag_out)
    else $error("overflow flag survived its clear");

  chk_count_step: assert property (
    timer_tick && waveform_mode == `TMC_WM_NORMAL && !count_wr_in
      |=> timer_count_value_out == tmc_byte_t'($past(st_ff.cnt) + tmc_byte_t'(1)))
    else $error("normal count did not step by one");

  // pin fall ticks in select 6
  chk_pin_fall: assert property (
    clock_source_select_in == `TMC_CS_EXT_FALL && pin_fall |-> timer_tick)
    else $error("falling pin edge did not tick");
endmodule : tmc_timer

// *** core/tmc_consts.svh ***
// Functional notes
// - count and two compares are 8-bit
// - select 1 ticks every system clock
// - prescaled rates divide by 8/64/256/1024
// - prescaler free runs, first count 1..N+1
// - prescaler reset aligns tick phase
// - pin synchronised then edge detected
// - latch transparent high, flops on rising
// - select 7 rising, 6 falling pin edges
// - pin edge to count 2.5-3.5 cycles
// - pin ticks bypass the prescaler
// - select 0 stops the counter
// - count readable and writable any time
// - count write beats clear and count
// - tick clears, increments or decrements
// - three-bit mode split over two controls
// - bottom 0x00, max 0xFF, top per mode
// - max and bottom indications are output
// - continuous compare sets compare flags
// - shared flags, each irq individually masked
// - overflow point depends on mode
// - flag set next tick, cleared by service
// - count write blocks next tick's match
// - mode 0 wraps, overflow at zero
// - clear-on-compare resets at compare a
//
// Purpose: offsets, field codes, reset values and counts for the timer
// Assumes: included by its bare name from the package and the core
// Notes: definitions only
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH
`define TMC_CNT_W 8
`define TMC_PSC_W 10
`define TMC_BOTTOM 8'h00
`define TMC_MAX 8'hff
`define TMC_CNT_RST 8'h00
`define TMC_PSC_RST 10'h000
`define TMC_PSC_M8 10'h007
`define TMC_PSC_M64 10'h03f
`define TMC_PSC_M256 10'h0ff
`define TMC_PSC_M1024 10'h3ff
`define TMC_CS_STOP 3'h0
`define TMC_CS_DIRECT 3'h1
`define TMC_CS_DIV8 3'h2
`define TMC_CS_DIV64 3'h3
`define TMC_CS_DIV256 3'h4
`define TMC_CS_DIV1024 3'h5
`define TMC_CS_EXT_FALL 3'h6
`define TMC_CS_EXT_RISE 3'h7
`define TMC_WM_NORMAL 3'h0
`define TMC_WM_PC_MAX 3'h1
`define TMC_WM_CTC 3'h2
`define TMC_WM_FAST_MAX 3'h3
`define TMC_WM_PC_CMPA 3'h5
`define TMC_WM_FAST_CMPA 3'h7
`define TMC_FLG_OVF 0
`define TMC_FLG_A 1
`define TMC_FLG_B 2
`define TMC_DIV8_GAP 7
`endif

// *** core/tmc_pkg.sv ***
// Purpose: shared types of the timer core
// Assumes: tmc_consts.svh holds every number
// Notes: state structs are registered whole
`include "tmc_consts.svh"
package tmc_pkg;
  typedef logic [`TMC_CNT_W-1:0] tmc_byte_t;
  typedef logic [`TMC_PSC_W-1:0] tmc_psc_t;

  // whole state of the counter core
  typedef struct packed {
    tmc_byte_t cnt;
    tmc_byte_t cmp_a;
    tmc_byte_t cmp_b;
    logic count_down;
    tmc_psc_t psc;
    logic block;
    logic flg_ovf;
    logic flg_a;
    logic flg_b;
  } tmc_core_s;

  // synchroniser stages behind the latch
  typedef struct packed {
    logic sync;
    logic prev;
    logic rise;
    logic fall;
  } tmc_sync_s;
endpackage : tmc_pkg

// *** core/tmc_pin_sync.sv ***
// Purpose: external count pin synchroniser and edge detector
// Assumes: pin is asynchronous to clk_in
// Notes: edge pulses are registered, one cycle wide
`timescale 1ns/1ps
module tmc_pin_sync
  import tmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic external_count_pin_in,
  output logic pin_rise_out,
  output logic pin_fall_out
);
  logic latch_ff;
  tmc_sync_s st_ff;
  tmc_sync_s nxt_st;

  // half-cycle capture stage
  // falling-edge flop stands in for the latch that is open while clock is high
  always_ff @(negedge clk_in) begin
    if (reset_in) begin
      latch_ff <= 1'b0;
    end else begin
      latch_ff <= external_count_pin_in;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync = latch_ff;
    nxt_st.prev = st_ff.sync;
    nxt_st.rise = st_ff.sync & ~st_ff.prev;
    nxt_st.fall = ~st_ff.sync & st_ff.prev;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // one registered pulse per edge
  // the extra pulse stage keeps the pin-to-count delay inside 2.5 to 3.5 cycles
  assign pin_rise_out = st_ff.rise;
  assign pin_fall_out = st_ff.fall;

  chk_edge_single: assert property (
    @(posedge clk_in) disable iff (reset_in) pin_rise_out |=> !pin_rise_out)
    else $error("rise pulse longer than one cycle");
endmodule : tmc_pin_sync

// *** test/tmc_timer_bench.sv ***
// Purpose: self-checking bench for the timer core through its plain ports
// Assumes: inputs move 1 ns after each rising edge, outputs are read there
// Notes: every wait is bounded; an exhausted wait counts a mismatch
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); end end
module tmc_timer_bench;
  import tmc_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] sel = 3'h0;
  logic wm0 = 1'b0;
  logic wm1 = 1'b0;
  logic wm2 = 1'b0;
  logic psc_rst = 1'b0;
  logic pin = 1'b0;
  logic cnt_wr = 1'b0;
  logic [7:0] cnt_wd = 8'h00;
  logic a_wr = 1'b0;
  logic [7:0] a_wd = 8'h00;
  logic b_wr = 1'b0;
  logic [7:0] b_wd = 8'h00;
  logic [2:0] fclr = 3'h0;
  logic [2:0] fack = 3'h0;
  logic m_ovf = 1'b0;
  logic m_a = 1'b0;
  logic m_b = 1'b0;
  logic [7:0] cnt, cmp_a, cmp_b;
  logic f_ovf, f_a, f_b, i_ovf, i_a, i_b, tick, at_max, at_bot, down, mt_a, mt_b;
  int err_total = 0;
  int n_tests = 0;
  int gaps[4] = '{8, 64, 256, 1024};

  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;

  tmc_timer i_dut (.clk_in(clk_in), .reset_in(reset_in), .clock_source_select_in(sel),
    .waveform_mode_bit0_in(wm0), .waveform_mode_bit1_in(wm1), .waveform_mode_bit2_in(wm2),
    .prescaler_reset_in(psc_rst), .external_count_pin_in(pin), .count_wr_in(cnt_wr),
    .count_wdata_in(cnt_wd), .compare_a_wr_in(a_wr), .compare_a_wdata_in(a_wd),
    .compare_b_wr_in(b_wr), .compare_b_wdata_in(b_wd), .flag_clear_in(fclr),
    .flag_ack_in(fack), .overflow_mask_in(m_ovf), .compare_a_mask_in(m_a),
    .compare_b_mask_in(m_b), .timer_count_value_out(cnt), .compare_value_a_out(cmp_a),
    .compare_value_b_out(cmp_b), .overflow_flag_out(f_ovf), .compare_flag_a_out(f_a),
    .compare_flag_b_out(f_b), .overflow_irq_out(i_ovf), .compare_a_irq_out(i_a),
    .compare_b_irq_out(i_b), .timer_tick_out(tick), .count_at_max_out(at_max),
    .count_at_bottom_out(at_bot), .count_down_out(down), .match_a_out(mt_a),
    .match_b_out(mt_b));

  // n cycles, inputs move just after the edge
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
    end
  endtask : step

  task automatic wr_cnt(input logic [7:0] v);
    cnt_wr = 1'b1;
    cnt_wd = v;
    step(1);
    cnt_wr = 1'b0;
  endtask : wr_cnt

  task automatic wr_cmp(input logic [7:0] va, input logic [7:0] vb);
    a_wr = 1'b1;
    a_wd = va;
    b_wr = 1'b1;
    b_wd = vb;
    step(1);
    a_wr = 1'b0;
    b_wr = 1'b0;
  endtask : wr_cmp

  // strobe flags away with the write-one clear
  task automatic clr_flags();
    fclr = 3'h7;
    step(1);
    fclr = 3'h0;
  endtask : clr_flags

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask : end_test

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // cycles until the count moves, bounded
  task automatic wait_move(output int n);
    logic [7:0] old;
    old = cnt;
    n = 0;
    while (cnt === old) begin
      step(1);
      n++;
      if (n > 2100) begin
        err_total++;
        complete_run();
      end
    end
  endtask : wait_move

  // one pin pulse, halves of three cycles keep sampling safe
  // pin held stable
  task automatic pin_pulse(input logic lvl);
    pin = lvl;
    step(3);
    pin = ~lvl;
    step(3);
  endtask : pin_pulse

  initial begin
    int n;
    int k;
    step(4);
    reset_in = 1'b0;
    step(1);
    `CHK({cnt, cmp_a, cmp_b, f_ovf, f_a, f_b}, 27'h000_0000)
    `CHK({at_bot, tick}, 2'b10)
    `CHK({mt_a, mt_b}, 2'b11)
    wr_cmp(8'h10, 8'h20);
    wr_cnt(8'h5a);
    `CHK({cnt, cmp_a, cmp_b}, 24'h5a_1020)
    step(5);
    `CHK({cnt, tick}, 9'h0b4)
    end_test("access_stop");
    // normal mode wrap and overflow flag
    wr_cnt(8'hfe);
    sel = 3'h1;
    step(1);
    `CHK({cnt, at_max, f_ovf, tick}, 11'h7fd)
    step(1);
    `CHK({cnt, at_bot, f_ovf, i_ovf}, 11'h006)
    // mask opened a cycle later, the flag still stands
    m_ovf = 1'b1;
    step(1);
    `CHK({cnt, i_ovf}, 9'h003)
    wr_cnt(8'h40);
    `CHK(cnt, 8'h40)
    step(1);
    `CHK(cnt, 8'h41)
    sel = 3'h0;
    fclr = 3'h1;
    step(1);
    fclr = 3'h0;
    `CHK(f_ovf, 1'b0)
    end_test("normal");
    // match blocked after a count write, then seen one lap later
    sel = 3'h1;
    wr_cnt(8'h10);
    step(1);
    `CHK({cnt, f_a}, 9'h022)
    k = 0;
    while (f_a !== 1'b1) begin
      step(1);
      k++;
      if (k > 300) begin
        err_total++;
        complete_run();
      end
    end
    `CHK(cnt, 8'h11)
    `CHK(k, 256)
    sel = 3'h0;
    m_a = 1'b1;
    m_b = 1'b1;
    step(1);
    `CHK({f_b, i_a, i_b}, 3'h7)
    fack = 3'h6;
    step(1);
    fack = 3'h0;
    `CHK({f_a, f_b, i_a, i_b}, 4'h0)
    end_test("compare");
    // divided taps give the exact gap
    for (int i = 0; i < 4; i++) begin
      sel = 3'h2 + 3'(i);
      psc_rst = 1'b1;
      step(1);
      psc_rst = 1'b0;
      wait_move(n);
      `CHK(n <= gaps[i] + 1, 1'b1)
      wait_move(n);
      `CHK(n, gaps[i])
    end
    sel = 3'h0;
    end_test("prescaler");
    // clear on compare a
    clr_flags();
    wm1 = 1'b1;
    wr_cmp(8'h05, 8'h20);
    wr_cnt(8'h03);
    sel = 3'h1;
    step(1);
    `CHK(cnt, 8'h04)
    step(1);
    `CHK({cnt, mt_a, mt_b}, 10'h016)
    step(1);
    `CHK({cnt, f_ovf}, 9'h000)
    // dual slope turn at max
    sel = 3'h0;
    wm1 = 1'b0;
    wm0 = 1'b1;
    wr_cnt(8'hfe);
    sel = 3'h1;
    step(2);
    `CHK({cnt, down}, 9'h1fd)
    step(1);
    `CHK(cnt, 8'hfd)
    // dual slope with top at compare a, turn at bottom
    sel = 3'h0;
    wm2 = 1'b1;
    wr_cnt(8'h01);
    sel = 3'h1;
    step(1);
    `CHK({cnt, down, f_ovf}, 10'h002)
    step(1);
    `CHK({cnt, down, f_ovf}, 10'h005)
    // fast mode with top at compare a
    sel = 3'h0;
    wm1 = 1'b1;
    clr_flags();
    wr_cnt(8'h04);
    sel = 3'h1;
    step(1);
    `CHK({cnt, f_ovf}, 9'h00a)
    step(1);
    `CHK({cnt, f_ovf}, 9'h001)
    sel = 3'h0;
    wm0 = 1'b0;
    wm1 = 1'b0;
    wm2 = 1'b0;
    end_test("modes");
    // external pin, rising then falling edges
    wr_cnt(8'h00);
    step(2);
    sel = 3'h7;
    step(2);
    pin = 1'b1;
    step(2);
    `CHK(cnt, 8'h00)
    step(1);
    `CHK(cnt, 8'h01)
    step(2);
    pin = 1'b0;
    step(3);
    repeat (3) pin_pulse(1'b1);
    step(4);
    `CHK(cnt, 8'h04)
    sel = 3'h6;
    step(2);
    wr_cnt(8'h00);
    repeat (3) pin_pulse(1'b1);
    step(4);
    `CHK(cnt, 8'h03)
    end_test("pin");
    // second reset in mid-run, flags a and overflow are standing here
    reset_in = 1'b1;
    step(2);
    reset_in = 1'b0;
    step(1);
    `CHK({cnt, cmp_a, cmp_b, f_ovf, f_a, f_b, down}, 28'h000_0000)
    `CHK({at_bot, mt_a, mt_b}, 3'h7)
    end_test("reset");
    complete_run();
  end
endmodule : tmc_timer_bench
